//--- common/gauge_params.svh
// Purpose: Named constants of the battery gauge measurement sequencer.
// Assumes: A 100 MHz system clock.
// Notes:   Definitions only; included by bare name.
`ifndef GAUGE_PARAMS_SVH
`define GAUGE_PARAMS_SVH
// ==========================================================
// Timing
`define CLK_KHZ        100000
`define SEQ_MS         1760
`define SEQ_SLOTS      8
`define SLEEP_MIN_MS   1500
`define SLEEP_MAX_MS   2200
`define CAL_LAST       10'h3ff
// ==========================================================
// Schedule slots
`define SLOT_VOLT_A    3'h0
`define SLOT_CURR_A    3'h1
`define SLOT_SETTLE_A  3'h2
`define SLOT_AUX_A     3'h3
`define SLOT_VOLT_B    3'h4
`define SLOT_CURR_B    3'h5
`define SLOT_SETTLE_B  3'h6
`define SLOT_AUX_B     3'h7
// ==========================================================
// Two-wire bus and register map
`define DEV_ADDR       7'h2a
`define REG_CFG        8'h01
`define REG_AUX0_MSB   8'h08
`define REG_AUX0_LSB   8'h09
`define REG_AUX1_MSB   8'h0a
`define REG_AUX1_LSB   8'h0b
`define REG_VOLT_MSB   8'h0c
`define REG_VOLT_LSB   8'h0d
`define REG_CURR_MSB   8'h0e
`define REG_CURR_LSB   8'h0f
`define REG_TEMP_MSB   8'h10
`define REG_TEMP_LSB   8'h11
`define REG_CURRENT_OFFSET_BIAS       8'h12
`define REG_ACC_B3     8'h14
`define REG_ACC_B2     8'h15
`define REG_ACC_B1     8'h16
`define REG_ACC_B0     8'h17
`define CFG_SLEEP_BIT  0
`define CFG_INTERNAL_TEMP_SELECT_BIT  1
`define CFG_ACTIVE_BIT 7
// ==========================================================
// Values
`define AUX_KEEP_MASK  16'hfff0
`define CURRENT_OFFSET_BIAS_RESET     8'h00
`define SAT_MAX        16'h7fff
`define SAT_MIN        16'h8000
`define ACC_LIMIT      32'sd536203636
`endif

//--- common/gauge_pkg.sv
// Purpose: Types of the battery gauge measurement sequencer.
// Assumes: Nothing beyond the parameter header.
// Notes:   One packed struct holds all state of the sequencer.
`default_nettype none
package gauge_pkg;
  // ==========================================================
  // Converter channels and bus states
  typedef enum logic [2:0] {
    CH_VOLT   = 3'h0,
    CH_CURR   = 3'h1,
    CH_AUX0   = 3'h2,
    CH_AUX1   = 3'h3,
    CH_TEMP   = 3'h4,
    CH_OFFSET = 3'h5
  } chan_t;

  typedef enum logic [3:0] {
    I_IDLE  = 4'h0,
    I_ADDR  = 4'h1,
    I_ACK_A = 4'h2,
    I_PTR   = 4'h3,
    I_ACK_P = 4'h4,
    I_WR    = 4'h5,
    I_ACK_W = 4'h6,
    I_RD    = 4'h7,
    I_ACK_R = 4'h8
  } i2c_state_t;

  // ==========================================================
  // Converter carriers
  typedef struct packed {
    logic  start;
    chan_t chan;
  } conv_req_t;

  typedef struct packed {
    logic               done;
    logic signed [19:0] data;
  } conv_rsp_t;

  // ==========================================================
  // Whole state of the sequencer
  typedef struct packed {
    logic               scl_m;
    logic               scl_s;
    logic               scl_p;
    logic               sda_m;
    logic               sda_s;
    logic               sda_p;
    logic               active;
    logic [27:0]        idle_cnt;
    logic [24:0]        slot_cnt;
    logic [2:0]         slot;
    logic               vout;
    conv_req_t          req;
    logic               busy;
    logic               cal;
    chan_t              chan;
    logic [9:0]         conv_cnt;
    logic signed [19:0] offset;
    logic [15:0]        volt;
    logic [15:0]        curr;
    logic [15:0]        temp;
    logic [15:0]        aux0;
    logic [15:0]        aux1;
    logic [7:0]         current_offset_bias;
    logic               sleep_en;
    logic               internal_temp_select;
    logic signed [31:0] acc;
    i2c_state_t         ist;
    logic [7:0]         shreg;
    logic [3:0]         bitcnt;
    logic [7:0]         ptr;
    logic               rw;
    logic               sda_oe;
  } gauge_state_t;
endpackage
`default_nettype wire

//--- logic/gauge_measure_sequencer.sv
// Purpose: Measurement sequencer, power modes and register file of a battery gauge.
// Assumes: Converter front end runs on clk_sys; bus pins are asynchronous.
// Notes:   Registers are reached over the two-wire bus; the accumulator is also driven on charge_accumulator.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_params.svh"

module gauge_measure_sequencer
  import gauge_pkg::*;
#(
  parameter int SLOT_CYCLES  = `SEQ_MS * `CLK_KHZ / `SEQ_SLOTS,
  parameter int SLEEP_CYCLES = `SLEEP_MIN_MS * `CLK_KHZ
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         scl_pin,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  output var conv_req_t     conv_req,
  input  wire conv_rsp_t    conv_rsp,
  output logic              vout_en,
  output logic              active,
  output logic signed [31:0] charge_accumulator
);
  localparam int SLEEP_MAX_CYCLES = `SLEEP_MAX_MS * `CLK_KHZ;

  gauge_state_t st;
  gauge_state_t next_st;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] sat16(input logic [21:0] v);
    if (v[21:15] == {7{v[21]}}) begin
      sat16 = v[15:0];
    end else if (v[21]) begin
      sat16 = `SAT_MIN;
    end else begin
      sat16 = `SAT_MAX;
    end
  endfunction

  function automatic logic [7:0] read_byte(input gauge_state_t s);
    case (s.ptr)
      `REG_CFG:      read_byte = {s.active, 5'h00, s.internal_temp_select, s.sleep_en};
      `REG_AUX0_MSB: read_byte = s.aux0[15:8];
      `REG_AUX0_LSB: read_byte = s.aux0[7:0];
      `REG_AUX1_MSB: read_byte = s.aux1[15:8];
      `REG_AUX1_LSB: read_byte = s.aux1[7:0];
      `REG_VOLT_MSB: read_byte = s.volt[15:8];
      `REG_VOLT_LSB: read_byte = s.volt[7:0];
      `REG_CURR_MSB: read_byte = s.curr[15:8];
      `REG_CURR_LSB: read_byte = s.curr[7:0];
      `REG_TEMP_MSB: read_byte = s.temp[15:8];
      `REG_TEMP_LSB: read_byte = s.temp[7:0];
      `REG_CURRENT_OFFSET_BIAS:     read_byte = s.current_offset_bias;
      `REG_ACC_B3:   read_byte = s.acc[31:24];
      `REG_ACC_B2:   read_byte = s.acc[23:16];
      `REG_ACC_B1:   read_byte = s.acc[15:8];
      `REG_ACC_B0:   read_byte = s.acc[7:0];
      default:       read_byte = 8'h00;
    endcase
  endfunction

  logic        bus_low;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [21:0] corr;
  logic [21:0] cur_sum;
  logic [15:0] cur_val;
  logic [32:0] acc_sum;
  // The read byte is taken once here, because a bit-select straight on a
  // function call is refused by strict front ends.
  logic [7:0]  rd_byte;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.scl_m = scl_pin;
    next_st.scl_s = st.scl_m;
    next_st.scl_p = st.scl_s;
    next_st.sda_m = sda_in;
    next_st.sda_s = st.sda_m;
    next_st.sda_p = st.sda_s;
    next_st.req.start = 1'b0;
    bus_low   = !st.scl_s && !st.sda_s;
    scl_rise  = st.scl_s && !st.scl_p;
    scl_fall  = !st.scl_s && st.scl_p;
    bus_start = st.scl_s && st.scl_p && st.sda_p && !st.sda_s;
    bus_stop  = st.scl_s && st.scl_p && !st.sda_p && st.sda_s;
    corr = {{2{conv_rsp.data[19]}}, conv_rsp.data} - {{2{st.offset[19]}}, st.offset};
    // Bias is 25 uV per step, which is sixteen current register counts.
    cur_sum = -corr + {{10{st.current_offset_bias[7]}}, st.current_offset_bias, 4'h0};
    cur_val = sat16(cur_sum);
    acc_sum = {st.acc[31], st.acc} + {{17{cur_val[15]}}, cur_val};
    rd_byte = read_byte(st);

    // Power modes.
    if (!st.active) begin
      next_st.idle_cnt = '0;
      if (!bus_low) begin
        next_st.active   = 1'b1;
        next_st.slot     = `SLOT_AUX_B;
        next_st.slot_cnt = 25'(SLOT_CYCLES - 1);
      end
    end else if (st.sleep_en && bus_low) begin
      next_st.idle_cnt = st.idle_cnt + 28'h1;
      if (st.idle_cnt == 28'(SLEEP_CYCLES - 1)) begin
        next_st.active = 1'b0;
        next_st.busy   = 1'b0;
      end
    end else begin
      next_st.idle_cnt = '0;
    end

    // Measurement schedule.
    if (st.active && next_st.active) begin
      if (st.slot_cnt == 25'(SLOT_CYCLES - 1)) begin
        next_st.slot_cnt = '0;
        next_st.slot     = st.slot + 3'h1;
        next_st.req.start = 1'b1;
        case (st.slot + 3'h1)
          `SLOT_VOLT_A, `SLOT_VOLT_B: next_st.chan = CH_VOLT;
          `SLOT_CURR_A, `SLOT_CURR_B: next_st.chan = CH_CURR;
          `SLOT_AUX_A:                next_st.chan = CH_AUX0;
          `SLOT_AUX_B:                next_st.chan = st.internal_temp_select ? CH_TEMP : CH_AUX1;
          default:                    next_st.req.start = 1'b0;
        endcase
        if (next_st.req.start) begin
          next_st.busy     = 1'b1;
          next_st.conv_cnt = st.conv_cnt + 10'h1;
          next_st.cal      = (st.conv_cnt == `CAL_LAST);
          next_st.req.chan = next_st.cal ? CH_OFFSET : next_st.chan;
        end
      end else begin
        next_st.slot_cnt = st.slot_cnt + 25'h1;
      end
    end

    // Results.
    if (st.active && st.busy && conv_rsp.done) begin
      next_st.busy = 1'b0;
      if (st.cal) begin
        next_st.offset = conv_rsp.data;
      end else begin
        unique case (st.chan)
          CH_VOLT: next_st.volt = sat16(corr);
          CH_CURR: begin
            next_st.curr = cur_val;
            if ($signed(acc_sum) > $signed({`ACC_LIMIT})) begin
              next_st.acc = `ACC_LIMIT;
            end else if ($signed(acc_sum) < -$signed({`ACC_LIMIT})) begin
              next_st.acc = -`ACC_LIMIT;
            end else begin
              next_st.acc = acc_sum[31:0];
            end
          end
          CH_AUX0: next_st.aux0 = sat16(corr) & `AUX_KEEP_MASK;
          CH_AUX1: next_st.aux1 = sat16(corr) & `AUX_KEEP_MASK;
          CH_TEMP: next_st.temp = sat16(corr);
          default: next_st.busy = 1'b0;
        endcase
      end
    end

    // Divider supply leads each auxiliary slot by one settle slot.
    next_st.vout = next_st.active && (next_st.slot == `SLOT_SETTLE_A ||
                   next_st.slot == `SLOT_AUX_A || (!st.internal_temp_select &&
                   (next_st.slot == `SLOT_SETTLE_B || next_st.slot == `SLOT_AUX_B)));

    // Two-wire register access, independent of the power mode.
    if (bus_start) begin
      next_st.ist    = I_ADDR;
      next_st.bitcnt = '0;
      next_st.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st.ist    = I_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      unique case (st.ist)
        I_IDLE: next_st.sda_oe = 1'b0;
        I_ADDR, I_PTR, I_WR: begin
          if (scl_rise) begin
            next_st.shreg  = {st.shreg[6:0], st.sda_s};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = '0;
            next_st.sda_oe = 1'b1;
            if (st.ist == I_ADDR) begin
              next_st.rw  = st.shreg[0];
              next_st.ist = (st.shreg[7:1] == `DEV_ADDR) ? I_ACK_A : I_IDLE;
              next_st.sda_oe = (st.shreg[7:1] == `DEV_ADDR);
            end else if (st.ist == I_PTR) begin
              next_st.ptr = st.shreg;
              next_st.ist = I_ACK_P;
            end else begin
              if (st.ptr == `REG_CFG) begin
                next_st.sleep_en = st.shreg[`CFG_SLEEP_BIT];
                next_st.internal_temp_select    = st.shreg[`CFG_INTERNAL_TEMP_SELECT_BIT];
              end
              if (st.ptr == `REG_CURRENT_OFFSET_BIAS) begin
                next_st.current_offset_bias = st.shreg;
              end
              next_st.ptr = st.ptr + 8'h1;
              next_st.ist = I_ACK_W;
            end
          end
        end
        I_ACK_A, I_ACK_P, I_ACK_W: begin
          if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            if (st.ist == I_ACK_A && st.rw) begin
              next_st.shreg  = rd_byte;
              next_st.ptr    = st.ptr + 8'h1;
              next_st.sda_oe = !rd_byte[7];
              next_st.ist    = I_RD;
            end else begin
              next_st.ist = (st.ist == I_ACK_A) ? I_PTR : I_WR;
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            next_st.shreg  = {st.shreg[6:0], 1'b0};
            next_st.bitcnt = st.bitcnt + 4'h1;
            next_st.sda_oe = !st.shreg[6];
            if (st.bitcnt == 4'h7) begin
              next_st.bitcnt = '0;
              next_st.sda_oe = 1'b0;
              next_st.ist    = I_ACK_R;
            end
          end
        end
        I_ACK_R: begin
          if (scl_rise && st.sda_s) begin
            next_st.ist = I_IDLE;
          end else if (scl_fall) begin
            next_st.shreg  = rd_byte;
            next_st.ptr    = st.ptr + 8'h1;
            next_st.sda_oe = !rd_byte[7];
            next_st.ist    = I_RD;
          end
        end
        default: begin
          next_st.ist    = I_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st        <= '0;
      st.active <= 1'b1;
      st.current_offset_bias   <= `CURRENT_OFFSET_BIAS_RESET;
      st.chan   <= CH_VOLT;
      st.ist    <= I_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out            = 1'b0;
  assign sda_oe             = st.sda_oe;
  assign conv_req           = st.req;
  assign vout_en            = st.vout;
  assign active             = st.active;
  assign charge_accumulator = st.acc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_lines_low;
    st.sleep_en && !st.scl_s && !st.sda_s;
  endsequence

  sequence s_aux0_start;
    st.req.start && st.req.chan == CH_AUX0;
  endsequence

  a_wake_on_line:  assert property (!st.active && (st.scl_s || st.sda_s) |=> st.active)
    else $error("No wake on a high bus line.");
  a_sleep_entry:   assert property ($fell(st.active) |-> $past(st.idle_cnt) ==
                     28'(SLEEP_CYCLES - 1) && $past(st.sleep_en))
    else $error("Sleep entered without full idle time.");
  a_sleep_window:  assert property (st.idle_cnt <= 28'(SLEEP_MAX_CYCLES))
    else $error("Idle count beyond longest idle time.");
  a_sleep_quiet:   assert property (!st.active |-> !st.req.start && !st.vout)
    else $error("Activity while asleep.");
  a_idle_restart:  assert property (s_lines_low ##1 (st.scl_s || st.sda_s) |=>
                     st.idle_cnt == '0)
    else $error("Idle wait not restarted.");
  a_vout_lead:     assert property (s_aux0_start |-> st.vout && $past(st.vout))
    else $error("Divider supply not ahead of auxiliary slot.");
  a_temp_no_vout:  assert property (st.req.start && st.chan == CH_TEMP |=>
                     !st.vout || !st.internal_temp_select)
    else $error("Divider supply on during temperature slot.");
  a_cal_hold:      assert property (st.busy && st.cal && conv_rsp.done |=>
                     $stable(st.volt) && $stable(st.curr) && $stable(st.acc))
    else $error("Register changed by a calibration conversion.");
  a_cal_period:    assert property (st.req.start && st.req.chan == CH_OFFSET |->
                     $past(st.conv_cnt) == `CAL_LAST)
    else $error("Calibration not on the 1024th conversion.");
  a_acc_clamp:     assert property ($signed(st.acc) <= $signed(`ACC_LIMIT) &&
                     $signed(st.acc) >= -$signed(`ACC_LIMIT))
    else $error("Accumulator beyond its range.");
  a_slot_pace:     assert property (st.req.start |=> !st.req.start [*8])
    else $error("Conversions started too close together.");

  // ==========================================================
  // Power mode and bus checks
  // A wake must restart the schedule at once, or the first voltage after
  // a long sleep would come a whole slot late.
  sequence s_woken;
    $rose(st.active);
  endsequence

  sequence s_first_volt;
    st.req.start && (st.req.chan == CH_VOLT || st.req.chan == CH_OFFSET);
  endsequence

  a_wake_restart:  assert property (s_woken |=> s_first_volt)
    else $error("Schedule not restarted after wake.");
  a_sleep_frozen:  assert property (!st.active |=> $stable(st.volt) &&
                     $stable(st.curr) && $stable(st.acc) && $stable(st.temp))
    else $error("Result changed while asleep.");
  a_oe_in_frame:   assert property (st.sda_oe |-> st.ist != I_IDLE)
    else $error("Data line driven outside a frame.");
  a_sleep_no_oe:   assert property (!st.active && st.ist == I_IDLE |-> !st.sda_oe)
    else $error("Data line driven while idle in sleep.");
endmodule
`default_nettype wire

//--- sim/gauge_measure_sequencer_tb_top.sv
// Purpose: Self-checking bench of the gauge measurement sequencer.
// Assumes: Short slot and idle counts; converter answers in five clocks.
// Notes:   Offset calibration lies beyond the run length and is left out.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_params.svh"
module gauge_measure_sequencer_tb_top;
  import gauge_pkg::*;
  localparam int SLOT = 200;
  localparam int SLP  = 500;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               scl_pin;
  logic               sda_low;
  logic               sda_line;
  logic               sda_out;
  logic               sda_oe;
  logic               vout_en;
  logic               active;
  logic signed [31:0] acc;
  conv_req_t          req;
  conv_rsp_t          rsp;
  logic signed [19:0] volt_val = 20'sh00800;
  logic signed [19:0] curr_val = 20'sh00000;
  int                 cyc = 0;
  int                 dcnt = 0;
  int                 errors = 0;
  int                 check_count = 0;
  chan_t              chans[$];
  int                 stamps[$];
  logic               vouts[$];
  // ==========================================
  // Wiring and converter model
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  always #5 clk_sys = ~clk_sys;
  host_model i_host (
    .clk_sys  (clk_sys),
    .sda_line (sda_line),
    .scl_pin  (scl_pin),
    .sda_low  (sda_low)
  );
  gauge_measure_sequencer #(.SLOT_CYCLES(SLOT), .SLEEP_CYCLES(SLP)) i_dut (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .scl_pin            (scl_pin),
    .sda_in             (sda_line),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .conv_req           (req),
    .conv_rsp           (rsp),
    .vout_en            (vout_en),
    .active             (active),
    .charge_accumulator (acc)
  );
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
    if (req.start === 1'b1) begin
      chans.push_back(req.chan);
      stamps.push_back(cyc);
      vouts.push_back(vout_en);
      dcnt <= 5;
    end else if (dcnt > 0) begin
      dcnt <= dcnt - 1;
    end
  end
  always @(posedge clk_sys) begin
    #1;
    rsp.done = (dcnt == 1);
    case (req.chan)
      CH_VOLT: rsp.data = volt_val;
      CH_CURR: rsp.data = curr_val;
      CH_AUX0: rsp.data = 20'sh00123;
      CH_AUX1: rsp.data = 20'sh00456;
      CH_TEMP: rsp.data = 20'sh00050;
      default: rsp.data = 20'sh00000;
    endcase
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clear();
    chans.delete();
    stamps.delete();
    vouts.delete();
  endtask
  task automatic wait_n(input int n);
    for (int i = 0; i < 4000 && chans.size() < n; i++) begin
      @(posedge clk_sys);
    end
    #2;
  endtask
  task automatic wait_chan(input chan_t c, output int t);
    for (int k = 0; k < 12; k++) begin
      clear();
      wait_n(1);
      t = stamps[0];
      if (chans[0] == c) break;
    end
    clear();
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] v;
    check(active, 1'b1);
    check(vout_en, 1'b0);
    check(acc, 32'h0);
    i_host.rd(`REG_CURRENT_OFFSET_BIAS, 1, v);
    check(v, `CURRENT_OFFSET_BIAS_RESET);
  endtask
  task automatic t_sched(input logic temp);
    chan_t       exp[6];
    int          t;
    logic [31:0] v;
    exp = '{CH_VOLT, CH_CURR, CH_AUX0, CH_VOLT, CH_CURR, temp ? CH_TEMP : CH_AUX1};
    i_host.wr(`REG_CFG, {6'h0, temp, 1'b0});
    wait_chan(temp ? CH_TEMP : CH_AUX1, t);
    wait_n(6);
    for (int i = 0; i < 6; i++) begin
      check(chans[i], exp[i]);
    end
    check(vouts[2], 1'b1);
    check(vouts[5], {31'h0, ~temp});
    check(stamps[3] - stamps[0], 4 * SLOT);
    check(stamps[5] - t, 8 * SLOT);
    i_host.rd(`REG_AUX0_MSB, 2, v);
    check(v, 32'h0120);
    i_host.rd(temp ? `REG_TEMP_MSB : `REG_AUX1_MSB, 2, v);
    check(v, temp ? 32'h0050 : 32'h0450);
    i_host.rd(`REG_VOLT_MSB, 2, v);
    check(v, 32'h0800);
  endtask
  task automatic t_current();
    int          t;
    logic [31:0] v;
    logic [31:0] a0;
    curr_val = -20'sd100;
    i_host.wr(`REG_CURRENT_OFFSET_BIAS, 8'h02);
    wait_chan(CH_CURR, t);
    a0 = acc;
    repeat (10) @(posedge clk_sys);
    check(acc - a0, 32'd132);
    i_host.rd(`REG_CURR_MSB, 2, v);
    check(v, 32'h0084);
  endtask
  task automatic t_sat();
    int          t;
    logic [31:0] v;
    volt_val = 20'sh0ffff;
    curr_val = 20'sh09c40;
    wait_chan(CH_VOLT, t);
    wait_chan(CH_AUX0, t);
    i_host.rd(`REG_VOLT_MSB, 2, v);
    check(v, `SAT_MAX);
    i_host.rd(`REG_CURR_MSB, 2, v);
    check(v, `SAT_MIN);
  endtask
  task automatic t_sleep();
    logic [31:0] v;
    i_host.wr(`REG_CFG, 8'h01);
    i_host.hold_low();
    repeat (SLP - 20) @(posedge clk_sys);
    #1;
    check(active, 1'b1);
    for (int i = 0; i < 100 && active !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    #1;
    check(active, 1'b0);
    clear();
    repeat (3 * SLOT) @(posedge clk_sys);
    check(chans.size(), 32'd0);
    i_host.stop();
    check(active, 1'b1);
    i_host.rd(`REG_CFG, 1, v);
    check(v, 32'h81);
  endtask
  initial begin
    rsp = '0;
    repeat (20) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset();
    t_sched(1'b0);
    t_sched(1'b1);
    t_current();
    t_sat();
    t_sleep();
    conclude();
  end
endmodule
`default_nettype wire

//--- sim/host_model.sv
// Purpose: Two-wire bus host model for the gauge bench.
// Assumes: Pull-up on the data line; bus clock period 80 ns.
// Notes:   Bus clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_params.svh"
module host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output var logic  scl_pin,
  output var logic  sda_low
);
  // ==========================================
  // Bit timing
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end
  // Half a bit is four clocks, so no low stretch nears the idle time.
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    half();
    scl_pin = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl_pin = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl_pin = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // Data changes only while the clock is low.
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~w[i];
      half();
      scl_pin = 1'b1;
      half();
      r[i] = sda_line;
      scl_pin = 1'b0;
    end
  endtask
  // ==========================================
  // Register access
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({`DEV_ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    xfer({d, 1'b1}, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n, output logic [31:0] v);
    logic [8:0] r;
    start();
    xfer({`DEV_ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    start();
    xfer({`DEV_ADDR, 1'b1, 1'b1}, r);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      xfer({8'hff, i == n - 1}, r);
      v = {v[23:0], r[8:1]};
    end
    stop();
  endtask
  task automatic hold_low();
    sda_low = 1'b1;
    half();
    scl_pin = 1'b0;
  endtask
endmodule
`default_nettype wire
